/* File: verif/kbc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Host side of the mailbox: single I/O cycles.
// ------------------------------------------------
module kbc_host_model (
  input  wire logic              sys_clk_i,
  output logic [15:0]            host_addr_o,
  output logic                   host_wr_o,
  output logic                   host_rd_o,
  output kbc_pkg::byte_type      host_wdata_o,
  input  wire kbc_pkg::byte_type host_rdata_i
);
  import kbc_pkg::*;

  initial begin
    host_addr_o = 16'hffff;
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_wdata_o = 8'h00;
  end

  // Released address and data show the inverse so stale values are never reused.
  task automatic xfer(input logic wr, input logic [15:0] a, input byte_type d,
                      output byte_type q);
    @(posedge sys_clk_i);
    host_addr_o <= a;
    host_wdata_o <= d;
    host_wr_o <= wr;
    host_rd_o <= !wr;
    @(posedge sys_clk_i);
    host_wr_o <= 1'b0;
    host_rd_o <= 1'b0;
    host_addr_o <= ~a;
    host_wdata_o <= ~d;
    @(negedge sys_clk_i);
    q = host_rdata_i;
  endtask
endmodule

`default_nettype wire

/* File: verif/test_kbc_host_mailbox_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "kbc_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module test_kbc_host_mailbox_port;
  import kbc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] ha;
  logic        hw, hr, kbd_host_irq, airq, ien, alu, osc, wcall, wnext, rst_o, a20, romwe, ramwe, od;
  byte_type    hwd, hrd, cwd, cin, cst, p1, romd, ramd, q;
  logic [9:0]  strb = '0;
  logic [1:0]  tin, cirq;
  logic [10:0] roma = '0;
  logic [7:0]  rama = '0;
  logic [3:0]  lo, loe, li, e;
  logic [2:0]  qo, qoe, qi;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #20 sys_clk_i = ~sys_clk_i;
  assign li = (loe & lo) | ~loe;
  assign qi = (qoe & qo) | ~qoe;

  kbc_host_model host (.sys_clk_i(sys_clk_i), .host_addr_o(ha), .host_wr_o(hw),
    .host_rd_o(hr), .host_wdata_o(hwd), .host_rdata_i(hrd));

  kbc_host_mailbox_port dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .host_addr_i(ha), .host_wr_i(hw), .host_rd_i(hr), .host_wdata_i(hwd),
    .host_rdata_o(hrd), .kbd_host_irq_o(kbd_host_irq), .aux_host_irq_o(airq),
    .cpu_wdata_i(cwd), .cpu_output_write_i(strb[0]), .cpu_data_rd_i(strb[1]),
    .cpu_status_wr_i(strb[2]), .cpu_flag_irq_enable_i(strb[3]),
    .cpu_port1_wr_i(strb[4]), .cpu_port2_wr_i(strb[5]), .cpu_idle_halt_i(strb[6]),
    .cpu_osc_stop_i(strb[7]), .cpu_ibf_irq_en_i(ien), .timer_ovf_i(strb[8]),
    .cpu_timer_ack_i(strb[9]), .cpu_in_data_o(cin), .cpu_status_o(cst),
    .cpu_port1_in_o(p1), .cpu_test_in_o(tin), .cpu_irq_o(cirq), .alu_run_o(alu),
    .osc_run_o(osc), .cpu_wake_call_o(wcall), .cpu_wake_next_o(wnext),
    .cpu_restart_o(rst_o), .cpu_rom_addr_i(roma), .cpu_rom_data_o(romd),
    .rom_load_we_i(romwe), .rom_load_addr_i(roma), .rom_load_data_i(cwd),
    .cpu_ram_addr_i(rama), .cpu_ram_we_i(ramwe), .cpu_ram_rdata_o(ramd),
    .a20_gate_o(a20), .kbd_aux_line_i(li), .kbd_aux_line_o(lo),
    .kbd_aux_line_oe_o(loe), .quasi_pin_i(qi), .quasi_pin_o(qo), .quasi_pin_oe_o(qoe),
    .ctrl_port_mode_i(1'b1), .open_drain_mode_i(od), .gp_input_cfg_i(3'b111),
    .gp_invert_cfg_i(3'b111));

  task automatic cpu_op(input int i, input byte_type d);
    @(posedge sys_clk_i);
    strb[i] <= 1'b1;
    cwd <= d;
    @(posedge sys_clk_i);
    strb[i] <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK("restart", 1'b1, rst_o)
    `CHK("kbd irq", 1'b0, kbd_host_irq)
    `CHK("line oe", 4'hf, loe)
    host.xfer(1'b0, `KBC_CMD_ADDR, 8'h00, q);
    `CHK("status", `KBC_STATUS_RESET, q)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end

  // ------------------------------------------------
  // Main sequence.
  // ------------------------------------------------
  initial begin
    cwd = 8'h00;
    ien = 1'b1;
    od = 1'b0;
    romwe = 1'b0;
    ramwe = 1'b0;
    do_reset();
    $display("done reset");
    host.xfer(1'b1, `KBC_CMD_ADDR, 8'ha5, q);
    `CHK("cmd flags", 4'b1010, cst[3:0])
    `CHK("cpu ibf irq", 1'b1, cirq[0])
    host.xfer(1'b1, `KBC_DATA_ADDR, 8'h3c, q);
    `CHK("data flag", 1'b0, cst[3])
    cpu_op(1, 8'h00);
    `CHK("cpu in", 8'h3c, cin)
    `CHK("ibf clr", 2'b00, {cst[1], cirq[0]})
    host.xfer(1'b1, 16'h0061, 8'h11, q);
    `CHK("unmapped wr", 1'b0, cst[1])
    cpu_op(0, 8'h96);
    host.xfer(1'b0, `KBC_CMD_ADDR, 8'h00, q);
    `CHK("host status", 8'h01, q)
    host.xfer(1'b0, `KBC_DATA_ADDR, 8'h00, q);
    `CHK("host data", 8'h96, q)
    `CHK("obf clr", 1'b0, cst[0])
    host.xfer(1'b0, 16'h0068, 8'h00, q);
    `CHK("unmapped rd", `KBC_UNMAPPED_READ, q)
    cpu_op(2, 8'hff);
    host.xfer(1'b0, `KBC_CMD_ADDR, 8'h00, q);
    `CHK("user bits", `KBC_USER_MASK, q)
    cpu_op(2, 8'h00);
    $display("done mailbox");
    foreach (strb[k]) begin
      if (k < 4) begin
        q = (8'h30 << k) ^ 8'h4a;
        cpu_op(5, q);
        @(negedge sys_clk_i);
        e = {q[2], q[3], q[7], q[6]};
        `CHK("line out", 4'h0, lo)
        `CHK("kbd irq", q[4], kbd_host_irq)
        `CHK("aux irq", q[5], airq)
        `CHK("a20", q[1], a20)
        `CHK("line oe", e, loe)
        `CHK("clk sense", {~e[2], ~e[0]}, tin)
        `CHK("data sense", {~e[3], ~e[1]}, p1[1:0])
      end
    end
    cpu_op(5, 8'h30);
    cpu_op(3, 8'h00);
    // The irq outputs take the new mode one edge after the enable lands.
    @(negedge sys_clk_i);
    `CHK("kbd en", 2'b01, {kbd_host_irq, airq})
    cpu_op(0, 8'h5a);
    `CHK("kbd obf", 1'b1, kbd_host_irq)
    host.xfer(1'b0, `KBC_DATA_ADDR, 8'h00, q);
    `CHK("kbd clr", 1'b0, kbd_host_irq)
    host.xfer(1'b1, `KBC_DATA_ADDR, 8'h21, q);
    `CHK("aux ibf", 1'b0, airq)
    cpu_op(1, 8'h00);
    `CHK("aux read", 1'b1, airq)
    cpu_op(0, 8'h77);
    cpu_op(5, 8'h00);
    `CHK("gated", 2'b00, {kbd_host_irq, airq})
    $display("done irq");
    // Quasi pins follow the port latch one edge later.
    cpu_op(4, 8'h7f);
    @(negedge sys_clk_i);
    `CHK("quasi low", 2'b10, {qoe[0], qo[0]})
    cpu_op(4, 8'hff);
    @(negedge sys_clk_i);
    `CHK("quasi high", 2'b11, {qoe[0], qo[0]})
    repeat (`KBC_QUASI_HOLD_CYC - 1) @(negedge sys_clk_i);
    `CHK("quasi hold", 1'b1, qoe[0])
    @(negedge sys_clk_i);
    `CHK("quasi rel", 1'b0, qoe[0])
    `CHK("quasi sense", 1'b1, p1[7])
    od = 1'b1;
    cpu_op(4, 8'h3b);
    @(negedge sys_clk_i);
    `CHK("od low", 6'b111000, {qoe, qo})
    cpu_op(4, 8'hff);
    @(negedge sys_clk_i);
    `CHK("od high", 3'b000, qoe)
    od = 1'b0;
    cpu_op(8, 8'h00);
    `CHK("timer", 1'b1, cirq[1])
    cpu_op(9, 8'h00);
    `CHK("timer ack", 1'b0, cirq[1])
    @(posedge sys_clk_i);
    romwe <= 1'b1;
    ramwe <= 1'b1;
    roma <= 11'h7ff;
    rama <= 8'hff;
    cwd <= 8'h69;
    @(posedge sys_clk_i);
    romwe <= 1'b0;
    ramwe <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("mem top", 16'h6969, {romd, ramd})
    $display("done pins");
    cpu_op(6, 8'h00);
    `CHK("halt", 1'b0, alu)
    host.xfer(1'b1, `KBC_DATA_ADDR, 8'h01, q);
    `CHK("wake call", 3'b110, {alu, wcall, wnext})
    cpu_op(1, 8'h00);
    ien = 1'b0;
    cpu_op(7, 8'h00);
    `CHK("stop", 1'b0, osc)
    host.xfer(1'b1, `KBC_DATA_ADDR, 8'h02, q);
    `CHK("wake next", 3'b101, {osc, wcall, wnext})
    cpu_op(6, 8'h00);
    do_reset();
    `CHK("reset run", 2'b11, {alu, osc})
    $display("done power");
    print_verdict();
  end
endmodule

`default_nettype wire

/* File: verilog/kbc_byte_store.sv */
`timescale 1ns/1ps
`default_nettype none

module kbc_byte_store #(
  parameter int AW = 8
) (
  input  wire logic sys_clk_i,
  kbc_mem_if.store  mem
);

  logic [7:0] cells [0:(1 << AW) - 1];

  // Read data leave through a register, write-first is not offered.
  always_ff @(posedge sys_clk_i) begin
    if (mem.we) begin
      cells[mem.addr] <= mem.wdata;
    end
    mem.rdata <= cells[mem.addr];
  end

endmodule

`default_nettype wire

/* File: verilog/kbc_host_mailbox_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "kbc_map.svh"

// Functional notes
// - CPU output write loads host read buffer, sets output full, may raise keyboard irq.
// - Host input write sets command flag from address bit two.
// - With flag irqs enabled, keyboard irq follows output full gated by port bit.
// - After reset the keyboard irq is low until firmware changes it.
// - Before flag irqs enabled, keyboard irq follows its port bit.
// - With flag irqs enabled, aux irq is inverse input full gated by port bit.
// - Before flag irqs enabled, aux irq follows its port bit.
// - A20 gate output comes from a firmware port bit.
// - Quasi pins: zero drives low, one drives high briefly then releases.
// - Open-drain pins never drive high; one releases the pin.
// - Controller port mode ignores input and invert configuration.
// - Four lines are inverted port bits, open drain, fed back to sense inputs.
// - Halt stops the ALU; reset or host input write wakes it.
// - Wake by reset restarts fetch at address zero.
// - Stop halts the oscillator; reset must be long enough to restart it.
// - CPU has two interrupt sources: input full and timer overflow.
// - 2K program store and 256 byte data RAM for the CPU.
// - CPU data read returns last host byte and clears input full.
// - Status byte: output full, input full, command flag, user bits.
// - Host input write sets input full and CPU interrupt; CPU read clears.
// - Host data read clears output full.
// - Reset clears status and drives all four lines low.
// - Data at 0x60, command and status at 0x64.
// - With flag irqs enabled, host data read clears keyboard irq.
module kbc_host_mailbox_port (
  input  wire logic                      sys_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [15:0]               host_addr_i,
  input  wire logic                      host_wr_i,
  input  wire logic                      host_rd_i,
  input  wire kbc_pkg::byte_type         host_wdata_i,
  output kbc_pkg::byte_type              host_rdata_o,
  output logic                           kbd_host_irq_o,
  output logic                           aux_host_irq_o,
  input  wire kbc_pkg::byte_type         cpu_wdata_i,
  input  wire logic                      cpu_output_write_i,
  input  wire logic                      cpu_data_rd_i,
  input  wire logic                      cpu_status_wr_i,
  input  wire logic                      cpu_flag_irq_enable_i,
  input  wire logic                      cpu_port1_wr_i,
  input  wire logic                      cpu_port2_wr_i,
  input  wire logic                      cpu_idle_halt_i,
  input  wire logic                      cpu_osc_stop_i,
  input  wire logic                      cpu_ibf_irq_en_i,
  input  wire logic                      timer_ovf_i,
  input  wire logic                      cpu_timer_ack_i,
  output kbc_pkg::byte_type              cpu_in_data_o,
  output kbc_pkg::byte_type              cpu_status_o,
  output kbc_pkg::byte_type              cpu_port1_in_o,
  output logic [1:0]                     cpu_test_in_o,
  output logic [1:0]                     cpu_irq_o,
  output logic                           alu_run_o,
  output logic                           osc_run_o,
  output logic                           cpu_wake_call_o,
  output logic                           cpu_wake_next_o,
  output logic                           cpu_restart_o,
  input  wire logic [`KBC_ROM_AW-1:0]    cpu_rom_addr_i,
  output kbc_pkg::byte_type              cpu_rom_data_o,
  input  wire logic                      rom_load_we_i,
  input  wire logic [`KBC_ROM_AW-1:0]    rom_load_addr_i,
  input  wire kbc_pkg::byte_type         rom_load_data_i,
  input  wire logic [`KBC_RAM_AW-1:0]    cpu_ram_addr_i,
  input  wire logic                      cpu_ram_we_i,
  output kbc_pkg::byte_type              cpu_ram_rdata_o,
  output logic                           a20_gate_o,
  input  wire logic [3:0]                kbd_aux_line_i,
  output logic [3:0]                     kbd_aux_line_o,
  output logic [3:0]                     kbd_aux_line_oe_o,
  input  wire logic [2:0]                quasi_pin_i,
  output logic [2:0]                     quasi_pin_o,
  output logic [2:0]                     quasi_pin_oe_o,
  input  wire logic                      ctrl_port_mode_i,
  input  wire logic                      open_drain_mode_i,
  input  wire logic [2:0]                gp_input_cfg_i,
  input  wire logic [2:0]                gp_invert_cfg_i
);
  import kbc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [3:0] QUASI_HOLD = 4'(`KBC_QUASI_HOLD_CYC);

  byte_type      in_buf;
  byte_type      out_buf;
  byte_type      user_bits;
  byte_type      port1;
  byte_type      port2;
  byte_type      host_rdata;
  byte_type      cpu_in_data;
  byte_type      port1_in;
  logic [1:0]    test_in;
  logic          output_buffer_full;
  logic          input_buffer_full;
  logic          cmd_flag;
  logic          flags_en;
  logic          kbd_host_irq;
  logic          aux_host_irq;
  logic          tmr_pend;
  logic          restart;
  logic          wake_call;
  logic          wake_next;
  pwr_state_type pwr;
  pwr_state_type next_pwr;

  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction

  // ----------------------------------------------------------------
  // Host decode and next values
  // ----------------------------------------------------------------
  wire logic     hit_data    = addr_hit(host_addr_i, `KBC_DATA_ADDR);
  wire logic     hit_cmd     = addr_hit(host_addr_i, `KBC_CMD_ADDR);
  wire logic     host_in_wr  = host_wr_i & (hit_data | hit_cmd);
  wire logic     host_out_rd = host_rd_i & hit_data;
  wire logic     next_obf    = cpu_output_write_i | (output_buffer_full & ~host_out_rd);
  wire logic     next_ibf    = host_in_wr | (input_buffer_full & ~cpu_data_rd_i);
  wire byte_type next_port2  = cpu_port2_wr_i ? cpu_wdata_i : port2;
  wire byte_type status      = {user_bits[7:4], cmd_flag, user_bits[2], input_buffer_full, output_buffer_full};
  wire logic     kbd_host_irq_bit    = next_port2[`KBC_P2_KBD_HOST_IRQ];
  wire logic     aux_host_irq_bit    = next_port2[`KBC_P2_AUX_HOST_IRQ];
  wire logic     next_kbd_host_irq   = flags_en ? (kbd_host_irq_bit & next_obf) : kbd_host_irq_bit;
  wire logic     next_aux_host_irq   = flags_en ? (aux_host_irq_bit & ~next_ibf) : aux_host_irq_bit;
  wire byte_type host_sel    = hit_data ? out_buf : (hit_cmd ? status : `KBC_UNMAPPED_READ);
  wire logic     cpu_active  = (pwr == PWR_RUN);

  // ----------------------------------------------------------------
  // Mailbox registers and status flags
  // ----------------------------------------------------------------
  // A flag set and its clear in the same cycle leave the flag set.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      output_buffer_full       <= 1'b0;
      input_buffer_full       <= 1'b0;
      cmd_flag  <= 1'b0;
      user_bits <= `KBC_STATUS_RESET & `KBC_USER_MASK;
    end else begin
      output_buffer_full <= next_obf;
      input_buffer_full <= next_ibf;
      if (host_in_wr) begin
        cmd_flag <= host_addr_i[`KBC_CMD_SEL_BIT];
      end
      if (cpu_status_wr_i) begin
        user_bits <= cpu_wdata_i & `KBC_USER_MASK;
      end
    end
  end

  // Data buffers have no reset value.
  always_ff @(posedge sys_clk_i) begin
    if (host_in_wr) begin
      in_buf <= host_wdata_i;
    end
    if (cpu_output_write_i) begin
      out_buf <= cpu_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      host_rdata  <= `KBC_UNMAPPED_READ;
      cpu_in_data <= `KBC_UNMAPPED_READ;
    end else begin
      if (host_rd_i) begin
        host_rdata <= host_sel;
      end
      if (cpu_data_rd_i) begin
        cpu_in_data <= in_buf;
      end
    end
  end

  // ----------------------------------------------------------------
  // Controller ports and host interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      port1    <= `KBC_PORT1_RESET;
      port2    <= `KBC_PORT2_RESET;
      flags_en <= 1'b0;
      kbd_host_irq     <= 1'b0;
      aux_host_irq     <= 1'b0;
    end else begin
      if (cpu_port1_wr_i) begin
        port1 <= cpu_wdata_i;
      end
      port2 <= next_port2;
      if (cpu_flag_irq_enable_i) begin
        flags_en <= 1'b1;
      end
      kbd_host_irq <= next_kbd_host_irq;
      aux_host_irq <= next_aux_host_irq;
    end
  end

  // Pin feedback is captured for the CPU's port and test reads.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      port1_in <= 8'h00;
      test_in  <= 2'h0;
    end else begin
      port1_in <= {quasi_pin_i[0], quasi_pin_i[1], port1[5:3], quasi_pin_i[2],
                   kbd_aux_line_i[3], kbd_aux_line_i[1]};
      test_in  <= {kbd_aux_line_i[2], kbd_aux_line_i[0]};
    end
  end

  // Lines are 0 kbd clock, 1 kbd data, 2 aux clock, 3 aux data; a set bit pulls low.
  assign kbd_aux_line_o    = 4'h0;
  assign kbd_aux_line_oe_o = {port2[`KBC_P2_AUX_DATA], port2[`KBC_P2_AUX_CLK],
                              port2[`KBC_P2_KBD_DATA], port2[`KBC_P2_KBD_CLK]};
  assign a20_gate_o        = port2[`KBC_P2_A20];

  // ----------------------------------------------------------------
  // Quasi-bidirectional pins
  // ----------------------------------------------------------------
  wire logic [2:0] quasi_val = {port1[`KBC_P1_QUASI_C], port1[`KBC_P1_QUASI_B],
                                port1[`KBC_P1_QUASI_A]};

  for (genvar i = 0; i < 3; i++) begin : g_quasi
    logic [3:0] hold_cnt;
    logic       eff_q;
    wire logic  eff   = quasi_val[i] ^ (gp_invert_cfg_i[i] & ~ctrl_port_mode_i);
    wire logic  gp_in = gp_input_cfg_i[i] & ~ctrl_port_mode_i;

    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        eff_q    <= 1'b1;
        hold_cnt <= 4'h0;
      end else begin
        eff_q <= eff;
        if (eff & ~eff_q) begin
          hold_cnt <= QUASI_HOLD;
        end else if (hold_cnt != 4'h0) begin
          hold_cnt <= hold_cnt - 4'h1;
        end
      end
    end

    assign quasi_pin_o[i]    = eff_q;
    assign quasi_pin_oe_o[i] = ~gp_in & (~eff_q | (~open_drain_mode_i & (hold_cnt != 4'h0)));
  end

  // ----------------------------------------------------------------
  // Power-down control
  // ----------------------------------------------------------------
  always_comb begin
    case (pwr)
      PWR_RUN: begin
        if (cpu_osc_stop_i) begin
          next_pwr = PWR_HARD;
        end else if (cpu_idle_halt_i) begin
          next_pwr = PWR_SOFT;
        end else begin
          next_pwr = PWR_RUN;
        end
      end
      PWR_SOFT, PWR_HARD: begin
        next_pwr = host_in_wr ? PWR_RUN : pwr;
      end
      default: begin
        next_pwr = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pwr       <= PWR_RUN;
      restart   <= 1'b1;
      wake_call <= 1'b0;
      wake_next <= 1'b0;
      tmr_pend  <= 1'b0;
    end else begin
      pwr       <= next_pwr;
      restart   <= 1'b0;
      wake_call <= ~cpu_active & host_in_wr & cpu_ibf_irq_en_i;
      wake_next <= ~cpu_active & host_in_wr & ~cpu_ibf_irq_en_i;
      tmr_pend  <= timer_ovf_i | (tmr_pend & ~cpu_timer_ack_i);
    end
  end

  assign alu_run_o       = cpu_active;
  assign osc_run_o       = (pwr != PWR_HARD);
  assign cpu_wake_call_o = wake_call;
  assign cpu_wake_next_o = wake_next;
  assign cpu_restart_o   = restart;
  assign cpu_irq_o       = {tmr_pend, input_buffer_full & cpu_ibf_irq_en_i};
  assign cpu_status_o    = status;
  assign cpu_in_data_o   = cpu_in_data;
  assign cpu_port1_in_o  = port1_in;
  assign cpu_test_in_o   = test_in;
  assign host_rdata_o    = host_rdata;
  assign kbd_host_irq_o  = kbd_host_irq;
  assign aux_host_irq_o  = aux_host_irq;

  // ----------------------------------------------------------------
  // Program store and data RAM
  // ----------------------------------------------------------------
  kbc_mem_if #(.AW(`KBC_ROM_AW)) rom_bus ();
  kbc_mem_if #(.AW(`KBC_RAM_AW)) ram_bus ();

  assign rom_bus.addr  = rom_load_we_i ? rom_load_addr_i : cpu_rom_addr_i;
  assign rom_bus.we    = rom_load_we_i;
  assign rom_bus.wdata = rom_load_data_i;
  assign ram_bus.addr  = cpu_ram_addr_i;
  assign ram_bus.we    = cpu_ram_we_i & cpu_active;
  assign ram_bus.wdata = cpu_wdata_i;

  kbc_byte_store #(.AW(`KBC_ROM_AW)) u_rom (
    .sys_clk_i (sys_clk_i),
    .mem       (rom_bus.store)
  );

  kbc_byte_store #(.AW(`KBC_RAM_AW)) u_ram (
    .sys_clk_i (sys_clk_i),
    .mem       (ram_bus.store)
  );

  assign cpu_rom_data_o  = rom_bus.rdata;
  assign cpu_ram_rdata_o = ram_bus.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_quasi_rise;
    $rose(g_quasi[0].eff_q) && ctrl_port_mode_i && !open_drain_mode_i;
  endsequence

  sequence s_sleep_write;
    (pwr != PWR_RUN) ##0 host_in_wr;
  endsequence

  a_obf_on_output: assert property (cpu_output_write_i |=> output_buffer_full && host_sel == out_buf || !hit_data)
    else $error("output full not set after CPU output write");
  a_cmd_flag_track: assert property (host_in_wr |=> cmd_flag == $past(host_addr_i[2]))
    else $error("command flag does not follow address bit");
  a_kbd_host_irq_source: assert property (kbd_host_irq_o == ($past(flags_en)
                  ? (port2[`KBC_P2_KBD_HOST_IRQ] & output_buffer_full) : port2[`KBC_P2_KBD_HOST_IRQ]))
    else $error("keyboard irq does not follow its source");
  a_aux_host_irq_source: assert property (aux_host_irq_o == ($past(flags_en)
                  ? (port2[`KBC_P2_AUX_HOST_IRQ] & ~input_buffer_full) : port2[`KBC_P2_AUX_HOST_IRQ]))
    else $error("aux irq does not follow its source");
  a_reset_state: assert property (@(posedge sys_clk_i) disable iff (1'b0)
                  $fell(sys_rst_i) |-> status == `KBC_STATUS_RESET && kbd_aux_line_oe_o == 4'hf
                  && !kbd_host_irq_o && cpu_restart_o)
    else $error("state after reset is wrong");
  a_quasi_release: assert property (s_quasi_rise |-> quasi_pin_oe_o[0] [*8]
                  ##5 (!quasi_pin_oe_o[0] || !quasi_pin_o[0] || open_drain_mode_i))
    else $error("quasi pin drive time is wrong");
  a_od_no_high: assert property (open_drain_mode_i |-> !(|(quasi_pin_oe_o & quasi_pin_o)))
    else $error("open-drain pin driven high");
  a_line_drive: assert property (cpu_port2_wr_i |=> kbd_aux_line_oe_o[1] == $past(cpu_wdata_i[7])
                  && kbd_aux_line_oe_o[0] == $past(cpu_wdata_i[6]))
    else $error("line drive does not follow port bits");
  a_ibf_cpu_read: assert property (cpu_data_rd_i && !host_in_wr |=> !input_buffer_full ##0 cpu_in_data_o == $past(in_buf))
    else $error("CPU read does not clear input full");
  a_obf_host_read: assert property (host_out_rd && !cpu_output_write_i |=> !output_buffer_full
                  && (!$past(flags_en) || !kbd_host_irq_o))
    else $error("host read does not clear output full");
  a_sleep_wake: assert property (s_sleep_write |=> alu_run_o && osc_run_o
                  && (cpu_wake_call_o != cpu_wake_next_o))
    else $error("host write does not wake the CPU");

endmodule

`default_nettype wire

/* File: verilog/kbc_map.svh */
`ifndef KBC_MAP_SVH
`define KBC_MAP_SVH

// ----------------------------------------------------------------
// Host I/O addresses and status layout
// ----------------------------------------------------------------
`define KBC_DATA_ADDR       16'h0060
`define KBC_CMD_ADDR        16'h0064
`define KBC_CMD_SEL_BIT     2
`define KBC_UNMAPPED_READ   8'h00
`define KBC_STATUS_RESET    8'h00
`define KBC_USER_MASK       8'hf4

// ----------------------------------------------------------------
// Controller port bits
// ----------------------------------------------------------------
`define KBC_P2_KBD_DATA     7
`define KBC_P2_KBD_CLK      6
`define KBC_P2_AUX_HOST_IRQ         5
`define KBC_P2_KBD_HOST_IRQ         4
`define KBC_P2_AUX_CLK      3
`define KBC_P2_AUX_DATA     2
`define KBC_P2_A20          1
`define KBC_P1_QUASI_A      7
`define KBC_P1_QUASI_B      6
`define KBC_P1_QUASI_C      2
`define KBC_PORT1_RESET     8'hff
`define KBC_PORT2_RESET     8'hcc

// ----------------------------------------------------------------
// Timing and memory sizes
// ----------------------------------------------------------------
`define KBC_CLK_NS          40
`define KBC_QUASI_HOLD_NS   500
`define KBC_QUASI_HOLD_CYC  (`KBC_QUASI_HOLD_NS / `KBC_CLK_NS)
`define KBC_ROM_AW          11
`define KBC_RAM_AW          8

`endif

/* File: verilog/kbc_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface kbc_mem_if #(parameter int AW = 8);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport user  (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

`default_nettype wire

/* File: verilog/kbc_pkg.sv */
`default_nettype none

package kbc_pkg;

  typedef logic [7:0] byte_type;

  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_SOFT = 3'b010,
    PWR_HARD = 3'b100
  } pwr_state_type;

endpackage

`default_nettype wire
